// >>> piet_defines.vh
// Purpose: Shared constants of the interval and event timer.
// Assumes: A 250 MHz system clock and a 10 MHz oscillator reference.
// Notes:   Register select codes follow the word address bit of the bus.
`ifndef PIET_DEFINES_VH
`define PIET_DEFINES_VH

// ============================================================
// Register selection
`define PIET_SEL_CSR 1'b0
`define PIET_SEL_BPR 1'b1

// ============================================================
// Control/status bit positions
`define PIET_GO 0
`define PIET_MODE_LO 1
`define PIET_MODE_HI 2
`define PIET_RATE_LO 3
`define PIET_RATE_HI 5
`define PIET_OVF_EN 6
`define PIET_OVF_FLAG 7
`define PIET_SIM_T1 8
`define PIET_SIM_T2 9
`define PIET_SIM_OSC 10
`define PIET_OSC_DIS 11
`define PIET_OVERRUN 12
`define PIET_TSE 13
`define PIET_T2_EN 14
`define PIET_T2_FLAG 15

// ============================================================
// Modes and clock-source codes
`define PIET_MODE_SINGLE 2'h0
`define PIET_MODE_REPEAT 2'h1
`define PIET_MODE_EVENT 2'h2
`define PIET_MODE_ZBASE 2'h3
`define PIET_RATE_STOP 3'h0
`define PIET_RATE_1M 3'h1
`define PIET_RATE_100K 3'h2
`define PIET_RATE_10K 3'h3
`define PIET_RATE_1K 3'h4
`define PIET_RATE_100 3'h5
`define PIET_RATE_T1 3'h6
`define PIET_RATE_LINE 3'h7

// ============================================================
// Reset values and timing
`define PIET_CSR_RST 16'h0000
`define PIET_BPR_RST 16'h0000
`define PIET_CNT_MAX 16'hFFFF
`define PIET_CLK_MHZ 250
`define PIET_OSC_MHZ 10
`define PIET_OSC_DIV (`PIET_CLK_MHZ / `PIET_OSC_MHZ)
`define PIET_DECADE 10
`define PIET_PULSE_NS 500
`define PIET_PULSE_CYC ((`PIET_PULSE_NS * `PIET_CLK_MHZ) / 1000)

`endif

// >>> piet_timer.v
// Purpose: Control/status, preset buffer and counter of an interval and
//          event timer reached from a processor bus.
// Assumes: Register strobes and bus_init are synchronous to clk; the
//          trigger and line inputs are asynchronous pins.
// Notes:   Pins pass two synchroniser flops before any edge is taken.
// Summary of operation
// - Setting start bit counts at rate chosen by clock-source field.
// - Mode 0 overflow clears start bit; other modes keep it set.
// - Clearing start bit or bus initialize resets and halts counter.
// - Mode bits: single, repeated, event timing, zero-base event timing.
// - Source codes: stop, 1 MHz, 100 kHz, 10 kHz, 1 kHz, 100 Hz, trigger one, line.
// - Overflow enable with overflow flag requests interrupt; clearing cancels.
// - Overflow sets flag; write zero, start rise or initialize clears.
// - Overflow request has priority over trigger-two request.
// - Trigger-one simulation bit acts like a trigger-one firing.
// - Trigger-two simulation bit acts like a trigger-two firing.
// - Oscillator simulation bit gives one tick while oscillator disabled.
// - Oscillator-disable bit stops the crystal from advancing the counter.
// - Simulation bits need no clearing and read back as zero.
// - Overrun set on repeat overflow or trigger two; cleared like flags.
// - Trigger-start enable: trigger-two flag sets start, clears enable.
// - Trigger-two enable with trigger-two flag requests; clearing cancels.
// - Trigger-two flag set on firing when start or trigger-start set.
// - Trigger-two flag cleared by write zero, initialize, some start rises.
// - Single interval loads preset on start, stops after overflow.
// - Repeated interval reloads preset each overflow and sets flag.
// - Event modes copy counter into preset register on trigger two.
// - Zero-base mode clears counter in the same cycle as the copy.
`timescale 1ns/1ps
`include "piet_defines.vh"

module piet_timer (
   input wire clk, // 250 MHz system clock
   input wire sys_rst, // synchronous reset, active high
   input wire clk_en, // freezes all state while low
   input wire bus_init, // bus initialize, active high
   input wire reg_sel, // word select: TIMER_CONTROL_STATUS or BUFFER_PRESET_REGISTER
   input wire reg_wr, // write strobe, one cycle
   input wire reg_rd, // read strobe, one cycle
   input wire [15:0] reg_wdata, // write data
   output reg [15:0] reg_rdata, // read data, valid after read
   input wire external_trigger_one, // trigger one pin, async
   input wire external_trigger_two, // trigger two pin, async
   input wire line_frequency_event, // line clock pin, async
   output reg overflow_pulse_out, // stretched overflow pulse
   output reg irq_req, // any enabled request pending
   output reg irq_from_trigger // request source: 0 overflow
);

// ============================================================
// Pin synchronisers and edge detection
   reg [2:0] sync1_ff;
   reg [2:0] sync2_ff;
   reg [2:0] sync3_ff;
   wire [2:0] pin_raw;
   wire [2:0] pin_edge;
   assign pin_raw = {line_frequency_event, external_trigger_two,
                     external_trigger_one};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (sys_rst) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
            end
         end
         assign pin_edge[gi] = sync2_ff[gi] & ~sync3_ff[gi];
      end
   endgenerate

// ============================================================
// Register state
   reg go_ff;
   reg go_dly_ff;
   reg [1:0] mode_ff;
   reg [2:0] rate_ff;
   reg ovf_en_ff;
   reg ovf_flag_ff;
   reg osc_dis_ff;
   reg overrun_ff;
   reg tse_ff;
   reg tse_fired_ff;
   reg t2_en_ff;
   reg t2_flag_ff;
   reg [15:0] bpr_ff;
   reg [15:0] cnt_ff;
   reg [4:0] osc_div_ff;
   reg [6:0] pulse_cnt_ff;
   reg nxt_go;
   reg [1:0] nxt_mode;
   reg [2:0] nxt_rate;
   reg nxt_ovf_en;
   reg nxt_ovf_flag;
   reg nxt_osc_dis;
   reg nxt_overrun;
   reg nxt_tse;
   reg nxt_tse_fired;
   reg nxt_t2_en;
   reg nxt_t2_flag;
   reg [15:0] nxt_bpr;
   reg [15:0] nxt_cnt;
   reg ovf_now;
   wire csr_wr;
   wire bpr_wr;
   wire go_rise;
   wire [15:0] csr_view;
   assign csr_wr = reg_wr & (reg_sel == `PIET_SEL_CSR);
   assign bpr_wr = reg_wr & (reg_sel == `PIET_SEL_BPR);
   assign go_rise = go_ff & ~go_dly_ff;

// ============================================================
// Oscillator and decade divider chain
   wire osc_raw;
   wire osc_tick;
   wire [5:0] dec_tick;
   wire t1_fire;
   wire t2_fire;
   reg cnt_tick;
   localparam integer OSC_LAST = `PIET_OSC_DIV - 1;
   localparam integer DEC_LAST = `PIET_DECADE - 1;
   localparam integer PULSE_LAST = `PIET_PULSE_CYC - 1;
   assign osc_raw = (osc_div_ff == OSC_LAST[4:0]);
   assign osc_tick = osc_dis_ff ? (csr_wr & reg_wdata[`PIET_SIM_OSC])
                                : osc_raw;
   assign dec_tick[0] = osc_tick;

   always @(posedge clk) begin
      if (sys_rst || (clk_en && osc_raw)) begin
         osc_div_ff <= 5'h00;
      end else if (clk_en) begin
         osc_div_ff <= osc_div_ff + 5'h01;
      end
   end

   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_decade
         reg [3:0] dec_ff;
         always @(posedge clk) begin
            if (sys_rst || (clk_en && dec_tick[gi+1])) begin
               dec_ff <= 4'h0;
            end else if (clk_en && dec_tick[gi]) begin
               dec_ff <= dec_ff + 4'h1;
            end
         end
         assign dec_tick[gi+1] = dec_tick[gi] & (dec_ff == DEC_LAST[3:0]);
      end
   endgenerate

   assign t1_fire = pin_edge[0] | (csr_wr & reg_wdata[`PIET_SIM_T1]);
   assign t2_fire = pin_edge[1] | (csr_wr & reg_wdata[`PIET_SIM_T2]);

   always @* begin
      case (rate_ff)
         `PIET_RATE_1M: cnt_tick = dec_tick[1];
         `PIET_RATE_100K: cnt_tick = dec_tick[2];
         `PIET_RATE_10K: cnt_tick = dec_tick[3];
         `PIET_RATE_1K: cnt_tick = dec_tick[4];
         `PIET_RATE_100: cnt_tick = dec_tick[5];
         `PIET_RATE_T1: cnt_tick = t1_fire;
         `PIET_RATE_LINE: cnt_tick = pin_edge[2];
         default: cnt_tick = 1'b0;
      endcase
   end

// ============================================================
// Next-state logic; later assignments win, so hardware sets beat clears.
   always @* begin
      nxt_go = go_ff;
      nxt_mode = mode_ff;
      nxt_rate = rate_ff;
      nxt_ovf_en = ovf_en_ff;
      nxt_ovf_flag = ovf_flag_ff;
      nxt_osc_dis = osc_dis_ff;
      nxt_overrun = overrun_ff;
      nxt_tse = tse_ff;
      nxt_tse_fired = tse_fired_ff;
      nxt_t2_en = t2_en_ff;
      nxt_t2_flag = t2_flag_ff;
      nxt_bpr = bpr_ff;
      nxt_cnt = cnt_ff;
      ovf_now = 1'b0;
      if (csr_wr) begin
         nxt_go = reg_wdata[`PIET_GO];
         nxt_mode = reg_wdata[`PIET_MODE_HI:`PIET_MODE_LO];
         nxt_rate = reg_wdata[`PIET_RATE_HI:`PIET_RATE_LO];
         nxt_ovf_en = reg_wdata[`PIET_OVF_EN];
         nxt_osc_dis = reg_wdata[`PIET_OSC_DIS];
         nxt_tse = reg_wdata[`PIET_TSE];
         nxt_t2_en = reg_wdata[`PIET_T2_EN];
         if (!reg_wdata[`PIET_OVF_FLAG]) begin
            nxt_ovf_flag = 1'b0;
         end
         if (!reg_wdata[`PIET_OVERRUN]) begin
            nxt_overrun = 1'b0;
         end
         if (!reg_wdata[`PIET_T2_FLAG]) begin
            nxt_t2_flag = 1'b0;
         end
      end
      if (bpr_wr) begin
         nxt_bpr = reg_wdata;
      end
      if (!go_ff) begin
         nxt_cnt = 16'h0000;
      end
      if (go_rise) begin
         nxt_ovf_flag = 1'b0;
         nxt_overrun = 1'b0;
         nxt_tse = 1'b0;
         if (!tse_fired_ff) begin
            nxt_t2_flag = 1'b0;
         end
         nxt_tse_fired = 1'b0;
         if (!mode_ff[1]) begin
            nxt_cnt = bpr_ff;
         end else begin
            nxt_cnt = 16'h0000;
         end
      end else if (go_ff && cnt_tick) begin
         if (cnt_ff == `PIET_CNT_MAX) begin
            ovf_now = 1'b1;
            nxt_overrun = nxt_overrun | ovf_flag_ff;
            nxt_ovf_flag = 1'b1;
            nxt_cnt = 16'h0000;
            if (mode_ff == `PIET_MODE_SINGLE) begin
               nxt_go = 1'b0;
            end
            if (mode_ff == `PIET_MODE_REPEAT) begin
               nxt_cnt = bpr_ff;
            end
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
         end
      end
      if (t2_fire && (go_ff || tse_ff)) begin
         nxt_overrun = nxt_overrun | t2_flag_ff;
         nxt_t2_flag = 1'b1;
         if (tse_ff) begin
            nxt_go = 1'b1;
            nxt_tse = 1'b0;
            nxt_tse_fired = 1'b1;
         end
         if (go_ff && mode_ff[1]) begin
            nxt_bpr = cnt_ff;
            if (mode_ff == `PIET_MODE_ZBASE) begin
               nxt_cnt = 16'h0000;
            end
         end
      end
   end

// ============================================================
// State registers
   always @(posedge clk) begin
      if (sys_rst || (clk_en && bus_init)) begin
         go_ff <= 1'b0;
         go_dly_ff <= 1'b0;
         mode_ff <= `PIET_MODE_SINGLE;
         rate_ff <= `PIET_RATE_STOP;
         ovf_en_ff <= 1'b0;
         ovf_flag_ff <= 1'b0;
         osc_dis_ff <= 1'b0;
         overrun_ff <= 1'b0;
         tse_ff <= 1'b0;
         tse_fired_ff <= 1'b0;
         t2_en_ff <= 1'b0;
         t2_flag_ff <= 1'b0;
         bpr_ff <= `PIET_BPR_RST;
         cnt_ff <= 16'h0000;
      end else if (clk_en) begin
         go_ff <= nxt_go;
         go_dly_ff <= go_ff;
         mode_ff <= nxt_mode;
         rate_ff <= nxt_rate;
         ovf_en_ff <= nxt_ovf_en;
         ovf_flag_ff <= nxt_ovf_flag;
         osc_dis_ff <= nxt_osc_dis;
         overrun_ff <= nxt_overrun;
         tse_ff <= nxt_tse;
         tse_fired_ff <= nxt_tse_fired;
         t2_en_ff <= nxt_t2_en;
         t2_flag_ff <= nxt_t2_flag;
         bpr_ff <= nxt_bpr;
         cnt_ff <= nxt_cnt;
      end
   end

// ============================================================
// Read path, requests and overflow pulse
   // Simulation bits read zero
   assign csr_view = {t2_flag_ff, t2_en_ff, tse_ff, overrun_ff,
                      osc_dis_ff, 3'h0, ovf_flag_ff, ovf_en_ff,
                      rate_ff, mode_ff, go_ff};

   always @(posedge clk) begin
      if (sys_rst || (clk_en && bus_init)) begin
         reg_rdata <= 16'h0000;
         irq_req <= 1'b0;
         irq_from_trigger <= 1'b0;
         overflow_pulse_out <= 1'b0;
         pulse_cnt_ff <= 7'h00;
      end else if (clk_en) begin
         if (reg_rd) begin
            if (reg_sel == `PIET_SEL_CSR) begin
               reg_rdata <= csr_view;
            end else begin
               reg_rdata <= bpr_ff;
            end
         end
         irq_req <= (ovf_en_ff & ovf_flag_ff) | (t2_en_ff & t2_flag_ff);
         irq_from_trigger <= ~(ovf_en_ff & ovf_flag_ff);
         // Stretched to 125 cycles for slow external logic; an overflow during the pulse restarts it.
         if (ovf_now) begin
            pulse_cnt_ff <= PULSE_LAST[6:0];
            overflow_pulse_out <= 1'b1;
         end else if (pulse_cnt_ff != 7'h00) begin
            pulse_cnt_ff <= pulse_cnt_ff - 7'h01;
         end else begin
            overflow_pulse_out <= 1'b0;
         end
      end
   end

endmodule // piet_timer

// >>> piet_evsrc.sv
// Purpose: Model of the pins on the far side of the timer.
// Assumes: The bench asks for one trigger pulse at a time.
// Notes:   The line input runs free, as a mains clock would.
`timescale 1ns/1ps
module piet_evsrc #(
   parameter LINE_HALF = 40
) (
   input wire clk, // bench clock
   input wire fire_one, // ask for a trigger-one pulse
   input wire fire_two, // ask for a trigger-two pulse
   output wire trig_one, // trigger-one pin
   output wire trig_two, // trigger-two pin
   output reg line_ev // line frequency pin
);
   reg [2:0] one_ff = 3'h0;
   reg [2:0] two_ff = 3'h0;
   integer line_cnt = 0;
   initial line_ev = 1'b0;
   // ====================
   // Pulse shaping
   // Three cycles high and three low, so the pin synchronisers see both.
   always @(posedge clk) begin
      if (fire_one && one_ff == 3'h0) one_ff <= 3'h6;
      else if (one_ff != 3'h0) one_ff <= one_ff - 3'h1;
      if (fire_two && two_ff == 3'h0) two_ff <= 3'h6;
      else if (two_ff != 3'h0) two_ff <= two_ff - 3'h1;
      line_cnt <= (line_cnt == LINE_HALF - 1) ? 0 : line_cnt + 1;
      if (line_cnt == LINE_HALF - 1) line_ev <= ~line_ev;
   end
   assign trig_one = one_ff > 3'h3;
   assign trig_two = two_ff > 3'h3;
endmodule // piet_evsrc

// >>> piet_timer_monitor.sv
// Purpose: Port-level checks of the interval and event timer.
// Assumes: One clock domain; bound to piet_timer.
// Notes:   Pulse length is counted in helper logic.
`timescale 1ns/1ps
module piet_mon (
   input wire clk, // system clock
   input wire sys_rst, // sync reset
   input wire clk_en, // run enable
   input wire bus_init, // bus initialize
   input wire reg_sel, // register select
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   input wire [15:0] reg_wdata, // write data
   input wire [15:0] reg_rdata, // read data
   input wire external_trigger_one, // trigger one pin
   input wire external_trigger_two, // trigger two pin
   input wire line_frequency_event, // line pin
   input wire overflow_pulse_out, // overflow pulse
   input wire irq_req, // request level
   input wire irq_from_trigger // request source
);
   reg [7:0] hi_cnt_ff;
   reg no_ovf_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ====================
   // Helper state
   always @(posedge clk) begin
      if (sys_rst || !overflow_pulse_out) hi_cnt_ff <= 8'h00;
      else if (clk_en && hi_cnt_ff != 8'hFF) hi_cnt_ff <= hi_cnt_ff + 8'h01;
      if (sys_rst || (bus_init && clk_en)) no_ovf_ff <= 1'b1;
      else if (overflow_pulse_out) no_ovf_ff <= 1'b0;
   end
   // ====================
   // Assertions
   a_sim_read_zero: assert property (
      reg_rd && clk_en && !reg_sel |=> reg_rdata[10:8] == 3'h0)
      else $error("simulation bits read back nonzero");
   a_init_clears_out: assert property (
      bus_init && clk_en |=> ##1 !irq_req && !overflow_pulse_out)
      else $error("outputs not cleared by bus initialize");
   a_init_halts_count: assert property (
      bus_init && clk_en |=> (!$rose(overflow_pulse_out))[*4])
      else $error("overflow right after bus initialize");
   a_pulse_min_len: assert property (
      $fell(overflow_pulse_out) && !$past(bus_init) && !$past(sys_rst)
      |-> hi_cnt_ff >= 8'h7D)
      else $error("overflow pulse too short");
   a_rdata_holds: assert property (
      !reg_rd && !bus_init && clk_en |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_irq_cancel: assert property (
      reg_wr && clk_en && !reg_sel && !reg_wdata[6] && !reg_wdata[14]
      |=> ##1 !irq_req)
      else $error("request kept after both enables cleared");
   a_flag_no_sw_set: assert property (
      reg_rd && clk_en && !reg_sel && no_ovf_ff && !overflow_pulse_out
      |=> !reg_rdata[7])
      else $error("overflow flag set without an overflow");
   a_freeze_holds: assert property (
      !clk_en && !bus_init |=> $stable(irq_req) && $stable(reg_rdata))
      else $error("outputs moved while frozen");
endmodule // piet_mon
bind piet_timer piet_mon u_mon (.clk(clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .bus_init(bus_init), .reg_sel(reg_sel),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .external_trigger_one(external_trigger_one),
   .external_trigger_two(external_trigger_two),
   .line_frequency_event(line_frequency_event),
   .overflow_pulse_out(overflow_pulse_out), .irq_req(irq_req),
   .irq_from_trigger(irq_from_trigger));

// >>> test_piet_timer.sv
// Purpose: Self-checking bench of the interval and event timer.
// Assumes: Read data settles one cycle after the strobe edge.
// Notes:   Inputs move on the falling edge; pins come from the model.
`timescale 1ns/1ps
module test_piet_timer;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic bus_init = 1'b0;
   logic reg_sel = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic fire_one = 1'b0;
   logic fire_two = 1'b0;
   logic rd_d = 1'b0;
   logic [31:0] rnd = 32'h1560DE1C;
   logic [15:0] exp_q[$];
   wire [15:0] reg_rdata;
   wire t_one, t_two, line_ev, ovf_out, irq_req, irq_src;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   piet_timer dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .bus_init(bus_init), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .external_trigger_one(t_one), .external_trigger_two(t_two),
      .line_frequency_event(line_ev), .overflow_pulse_out(ovf_out),
      .irq_req(irq_req), .irq_from_trigger(irq_src));
   piet_evsrc u_src (.clk(clk), .fire_one(fire_one), .fire_two(fire_two),
      .trig_one(t_one), .trig_two(t_two), .line_ev(line_ev));
   // ====================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic s, input logic [15:0] d);
      @(negedge clk);
      reg_sel = s;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic s, input logic [15:0] e);
      @(negedge clk);
      reg_sel = s;
      reg_rd = 1'b1;
      exp_q.push_back(e);
      @(negedge clk);
      reg_rd = 1'b0;
   endtask
   task automatic fire(input logic two);
      @(negedge clk);
      fire_one = !two;
      fire_two = two;
      @(negedge clk);
      fire_one = 1'b0;
      fire_two = 1'b0;
      repeat (10) @(negedge clk);
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ====================
   // Watcher and time limit
   always @(posedge clk) begin
      rd_d <= reg_rd && clk_en;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done;
      end
   end
   always @(negedge clk) begin
      if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
   end
   // ====================
   // Scenarios
   initial begin
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      rd(0, 16'h0000);
      rd(1, 16'h0000);
      wr(0, 16'h0FFE);
      rd(0, 16'h087E);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr(1, rnd[15:0]);
         rd(1, rnd[15:0]);
         wr(0, {10'h000, i[2:0], 3'h2});
         rd(0, {10'h000, i[2:0], 3'h2});
      end
      wr(1, 16'hFFFD);
      wr(0, 16'h0071);
      repeat (3) @(negedge clk);
      wr(0, 16'h0171);
      wr(0, 16'h0171);
      fire(0);
      chk("ovf_out", {15'h0000, ovf_out}, 16'h0001);
      chk("irq", {14'h0000, irq_req, irq_src}, 16'h0002);
      rd(0, 16'h00F0);
      wr(0, 16'h0030);
      repeat (2) @(negedge clk);
      chk("irq_req", {15'h0000, irq_req}, 16'h0000);
      wr(1, 16'hFFFF);
      wr(0, 16'h4073);
      fire(0);
      fire(0);
      fire(1);
      chk("irq", {14'h0000, irq_req, irq_src}, 16'h0002);
      rd(0, 16'hD0F3);
      wr(0, 16'hD0F2);
      rd(0, 16'hD0F2);
      wr(0, 16'hD0F3);
      rd(0, 16'h4073);
      wr(1, 16'h0000);
      wr(0, 16'h6036);
      fire(1);
      rd(0, 16'hC037);
      chk("irq", {14'h0000, irq_req, irq_src}, 16'h0003);
      repeat (3) fire(0);
      wr(0, 16'h4237);
      rd(1, 16'h0003);
      fire(0);
      fire(0);
      fire(1);
      rd(1, 16'h0002);
      rd(0, 16'hD037);
      @(negedge clk);
      bus_init = 1'b1;
      @(negedge clk);
      bus_init = 1'b0;
      rd(0, 16'h0000);
      rd(1, 16'h0000);
      wr(1, 16'hFFFF);
      wr(0, 16'h080B);
      repeat (300) @(negedge clk);
      rd(0, 16'h080B);
      repeat (10) wr(0, 16'h0C8B);
      repeat (4) @(negedge clk);
      rd(0, 16'h088B);
      wr(0, 16'h0009);
      clk_en = 1'b0;
      repeat (5) @(negedge clk);
      clk_en = 1'b1;
      repeat (600) @(negedge clk);
      rd(0, 16'h0088);
      wr(0, 16'h0035);
      repeat (2) fire(0);
      fire(1);
      fire(0);
      fire(1);
      rd(1, 16'h0003);
      rd(0, 16'h9035);
      repeat (3) @(negedge clk);
      test_done;
   end
endmodule // test_piet_timer
